// *** wsc_map.svh ***
// Operation
// - enable runs comparator; mode values 0-2
// - mode 0: mask and times only
// - mode 1: special dates also switch
// - mode 2: special dates never switch
// - special date handling overrides weekday mask
// - modes 1/2 need loaded table, else error
// - 7-bit weekday mask, Sunday weight 1
// - times are hour*100+minute, 0-2359
// - time 10000 disables that comparison
// - on after off: hold through midnight
// - bad mode, mask or time: error
// - load stores up to 20 entries
// - entries are month*100+day, 101-1231
// - bad entry raises error
// - weekday 0 Sunday to 6 Saturday
`ifndef WSC_MAP_SVH
`define WSC_MAP_SVH

// ****************************************
// register offsets
// ****************************************
`define WSC_OFF_CTRL    8'h00
`define WSC_OFF_MASK    8'h04
`define WSC_OFF_ON      8'h08
`define WSC_OFF_OFF     8'h0c
`define WSC_OFF_TCNT    8'h10
`define WSC_OFF_STAT    8'h14
`define WSC_OFF_IMSK    8'h18
`define WSC_OFF_TBL     8'h40

// ****************************************
// fields
// ****************************************
`define WSC_CTRL_EN     0
`define WSC_CTRL_LOAD   1
`define WSC_CTRL_MODE   2
`define WSC_ST_ERR      0
`define WSC_ST_ON       1
`define WSC_ST_OFF      2
`define WSC_ST_OUT      8
`define WSC_ST_LOADED   9
`define WSC_EV_W        3

// ****************************************
// limits
// ****************************************
`define WSC_TIME_OFF    14'h2710
`define WSC_TIME_MAX    14'h937
`define WSC_MIN_MAX     14'h3b
`define WSC_MASK_MAX    8'h7f
`define WSC_MONTH_MAX   11'hc
`define WSC_DAY_MAX     11'h1f
`define WSC_TBL_DEPTH   20
`define WSC_IDX_W       5
`define WSC_WD_SAT      3'h6

`endif

// *** wsc_pkg.sv ***
package wsc_pkg;
	typedef logic [31:0] wsc_word_t;
	typedef logic [13:0] wsc_time_t;
	typedef logic [10:0] wsc_date_t;
	typedef enum logic [1:0] {MODE_NORMAL, MODE_ADD, MODE_SKIP, MODE_BAD} wsc_mode_t;
endpackage

// *** wsc_tbl_if.sv ***
`timescale 1ns/1ps
`include "wsc_map.svh"
interface wsc_tbl_if;
	logic                      wr_en;
	logic [`WSC_IDX_W-1:0]     wr_idx;
	wsc_pkg::wsc_date_t        wr_data;
	logic                      load;
	logic [`WSC_IDX_W-1:0]     count;
	logic [`WSC_IDX_W-1:0]     rd_idx;
	wsc_pkg::wsc_date_t        rd_data;
	wsc_pkg::wsc_date_t        look_date;
	logic                      hit;
	logic                      bad;
	logic                      loaded;
	modport owner (output wr_en, wr_idx, wr_data, load, count, rd_idx, look_date,
		input rd_data, hit, bad, loaded);
	modport keeper (input wr_en, wr_idx, wr_data, load, count, rd_idx, look_date,
		output rd_data, hit, bad, loaded);
endinterface

// *** wsc_time_cmp.sv ***
`timescale 1ns/1ps
`include "wsc_map.svh"
module wsc_time_cmp (
	input  wire wsc_pkg::wsc_time_t preset,
	input  wire wsc_pkg::wsc_time_t cur_code,
	output logic                    hit,
	output logic                    bad
);
	import wsc_pkg::*;

	logic off;
	logic [13:0] minute;

	always_comb begin
		off    = (preset == `WSC_TIME_OFF);
		minute = preset % 14'h64;
		hit    = !off && (preset == cur_code);
		bad    = !off && ((preset > `WSC_TIME_MAX) || (minute > `WSC_MIN_MAX));
	end
endmodule // wsc_time_cmp

// *** wsc_day_table.sv ***
`timescale 1ns/1ps
`include "wsc_map.svh"
module wsc_day_table #(
	parameter int DEPTH = `WSC_TBL_DEPTH
) (
	input  wire logic  pclk,
	input  wire logic  presetn,
	wsc_tbl_if.keeper  tb
);
	import wsc_pkg::*;

	wsc_date_t             stage_q [DEPTH];
	wsc_date_t             stage_d [DEPTH];
	wsc_date_t             act_q   [DEPTH];
	wsc_date_t             act_d   [DEPTH];
	logic [`WSC_IDX_W-1:0] n_q;
	logic [`WSC_IDX_W-1:0] n_d;
	logic                  loaded_q;
	logic                  loaded_d;
	logic [DEPTH-1:0]      hit_v;
	logic [DEPTH-1:0]      bad_v;

	function automatic logic date_ok(input wsc_date_t d);
		wsc_date_t m;
		wsc_date_t dd;
		m  = d / 11'h64;
		dd = d % 11'h64;
		return (m != 11'h0) && (m <= `WSC_MONTH_MAX) && (dd != 11'h0) && (dd <= `WSC_DAY_MAX);
	endfunction

	// ****************************************
	// per entry match and range check
	// ****************************************
	for (genvar i = 0; i < DEPTH; i++) begin : g_ent
		assign hit_v[i] = (i < int'(n_q)) && (act_q[i] == tb.look_date);
		assign bad_v[i] = (i < int'(tb.count)) && !date_ok(stage_q[i]);
	end

	always_comb begin
		stage_d  = stage_q;
		act_d    = act_q;
		n_d      = n_q;
		loaded_d = loaded_q;
		if (tb.wr_en && (int'(tb.wr_idx) < DEPTH)) begin
			stage_d[tb.wr_idx] = tb.wr_data;
		end
		if (tb.load) begin
			act_d    = stage_q;
			n_d      = (int'(tb.count) > DEPTH) ? `WSC_IDX_W'(DEPTH) : tb.count;
			loaded_d = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < DEPTH; i++) begin
				stage_q[i] <= '0;
				act_q[i]   <= '0;
			end
			n_q      <= '0;
			loaded_q <= 1'b0;
		end else begin
			stage_q  <= stage_d;
			act_q    <= act_d;
			n_q      <= n_d;
			loaded_q <= loaded_d;
		end
	end

	assign tb.hit     = |hit_v;
	assign tb.loaded  = loaded_q;
	assign tb.bad     = tb.load && ((|bad_v) || (int'(tb.count) > DEPTH));
	assign tb.rd_data = (int'(tb.rd_idx) < DEPTH) ? stage_q[tb.rd_idx] : '0;
endmodule // wsc_day_table

// *** wsc_top.sv ***
`timescale 1ns/1ps
`include "wsc_map.svh"
module wsc_top (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire wsc_pkg::wsc_word_t pwdata,
	output wsc_pkg::wsc_word_t     prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic [2:0]        cal_weekday,
	input  wire logic [3:0]        cal_month,
	input  wire logic [4:0]        cal_day,
	input  wire logic [4:0]        cal_hour,
	input  wire logic [5:0]        cal_minute,
	output logic                   schedule_output,
	output logic                   error_indicator,
	output logic                   irq
);
	import wsc_pkg::*;

	// ****************************************
	// register state
	// ****************************************
	logic                  en_q;
	logic                  en_d;
	wsc_mode_t             mode_q;
	wsc_mode_t             mode_d;
	logic [7:0]            mask_q;
	logic [7:0]            mask_d;
	wsc_time_t             on_q;
	wsc_time_t             on_d;
	wsc_time_t             off_q;
	wsc_time_t             off_d;
	logic [`WSC_IDX_W-1:0] cnt_q;
	logic [`WSC_IDX_W-1:0] cnt_d;
	logic [`WSC_EV_W-1:0]  stat_q;
	logic [`WSC_EV_W-1:0]  stat_d;
	logic [`WSC_EV_W-1:0]  imsk_q;
	logic [`WSC_EV_W-1:0]  imsk_d;
	wsc_word_t             prdata_q;
	wsc_word_t             prdata_d;

	// ****************************************
	// schedule state
	// ****************************************
	logic                  out_q;
	logic                  out_d;
	logic                  on_hit_q;
	logic                  off_hit_q;
	logic                  day_ok_q;
	logic                  prev_ok_q;
	logic                  prev_ok_d;
	wsc_time_t             last_code_q;

	logic                  setup;
	logic                  wr;
	logic                  in_tbl;
	logic                  mapped;
	logic [7:0]            tbl_off;
	logic [`WSC_IDX_W-1:0] tidx;
	logic                  load;
	wsc_word_t             rdata;
	wsc_time_t             cur_code;
	logic                  on_hit;
	logic                  off_hit;
	logic                  on_bad;
	logic                  off_bad;
	logic                  mask_bit;
	logic                  day_ok;
	logic                  overnight;
	logic                  off_ok;
	logic                  rollover;
	logic                  mode_err;
	logic                  mask_err;
	logic                  time_err;
	logic                  tbl_err;
	logic                  cfg_err;
	logic                  run;
	logic                  on_fire;
	logic                  off_fire;
	logic [`WSC_EV_W-1:0]  ev;

	wsc_tbl_if tbl ();

	wsc_day_table #(.DEPTH(`WSC_TBL_DEPTH)) u_table (
		.pclk    (pclk),
		.presetn (presetn),
		.tb      (tbl.keeper)
	);

	wsc_time_cmp u_on (
		.preset   (on_q),
		.cur_code (cur_code),
		.hit      (on_hit),
		.bad      (on_bad)
	);

	wsc_time_cmp u_off (
		.preset   (off_q),
		.cur_code (cur_code),
		.hit      (off_hit),
		.bad      (off_bad)
	);

	// ****************************************
	// apb decode
	// ****************************************
	always_comb begin
		tbl_off = paddr - `WSC_OFF_TBL;
		tidx    = `WSC_IDX_W'(tbl_off >> 2);
		// whole offset checked so high addresses cannot alias entries
		in_tbl  = (paddr >= `WSC_OFF_TBL) && ((tbl_off >> 2) < 8'(`WSC_TBL_DEPTH));
		mapped  = (paddr[1:0] == 2'b00) && (in_tbl
			|| (paddr == `WSC_OFF_CTRL) || (paddr == `WSC_OFF_MASK)
			|| (paddr == `WSC_OFF_ON) || (paddr == `WSC_OFF_OFF)
			|| (paddr == `WSC_OFF_TCNT) || (paddr == `WSC_OFF_STAT)
			|| (paddr == `WSC_OFF_IMSK));
		setup   = psel && !penable;
		wr      = psel && penable && pwrite && mapped;
		load    = wr && (paddr == `WSC_OFF_CTRL) && pwdata[`WSC_CTRL_LOAD];
	end

	assign tbl.wr_en     = wr && in_tbl;
	assign tbl.wr_idx    = tidx;
	assign tbl.wr_data   = pwdata[10:0];
	assign tbl.load      = load;
	assign tbl.count     = cnt_q;
	assign tbl.rd_idx    = tidx;
	assign tbl.look_date = 11'(cal_month) * 11'd100 + 11'(cal_day);

	// ****************************************
	// read mux
	// ****************************************
	always_comb begin
		rdata = '0;
		if (in_tbl) begin
			rdata[10:0] = tbl.rd_data;
		end else begin
			case (paddr)
				`WSC_OFF_CTRL: begin
					rdata[`WSC_CTRL_EN]            = en_q;
					rdata[`WSC_CTRL_MODE+:2]       = mode_q;
				end
				`WSC_OFF_MASK: rdata[7:0]               = mask_q;
				`WSC_OFF_ON:   rdata[13:0]              = on_q;
				`WSC_OFF_OFF:  rdata[13:0]              = off_q;
				`WSC_OFF_TCNT: rdata[`WSC_IDX_W-1:0]    = cnt_q;
				`WSC_OFF_STAT: begin
					rdata[`WSC_EV_W-1:0]           = stat_q;
					rdata[`WSC_ST_OUT]             = out_q;
					rdata[`WSC_ST_LOADED]          = tbl.loaded;
				end
				`WSC_OFF_IMSK: rdata[`WSC_EV_W-1:0]     = imsk_q;
				default:       rdata                    = '0;
			endcase
		end
	end

	// ****************************************
	// register writes
	// ****************************************
	always_comb begin
		en_d     = en_q;
		mode_d   = mode_q;
		mask_d   = mask_q;
		on_d     = on_q;
		off_d    = off_q;
		cnt_d    = cnt_q;
		imsk_d   = imsk_q;
		prdata_d = setup ? rdata : prdata_q;
		stat_d   = stat_q | ev;
		if (wr) begin
			case (paddr)
				`WSC_OFF_CTRL: begin
					en_d   = pwdata[`WSC_CTRL_EN];
					mode_d = wsc_mode_t'(pwdata[`WSC_CTRL_MODE+:2]);
				end
				`WSC_OFF_MASK: mask_d = pwdata[7:0];
				`WSC_OFF_ON:   on_d   = pwdata[13:0];
				`WSC_OFF_OFF:  off_d  = pwdata[13:0];
				`WSC_OFF_TCNT: cnt_d  = pwdata[`WSC_IDX_W-1:0];
				`WSC_OFF_STAT: stat_d = (stat_q & ~pwdata[`WSC_EV_W-1:0]) | ev;
				`WSC_OFF_IMSK: imsk_d = pwdata[`WSC_EV_W-1:0];
				default:       stat_d = stat_q | ev;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_q     <= 1'b0;
			mode_q   <= MODE_NORMAL;
			mask_q   <= '0;
			on_q     <= `WSC_TIME_OFF;
			off_q    <= `WSC_TIME_OFF;
			cnt_q    <= '0;
			stat_q   <= '0;
			imsk_q   <= '0;
			prdata_q <= '0;
		end else begin
			en_q     <= en_d;
			mode_q   <= mode_d;
			mask_q   <= mask_d;
			on_q     <= on_d;
			off_q    <= off_d;
			cnt_q    <= cnt_d;
			stat_q   <= stat_d;
			imsk_q   <= imsk_d;
			prdata_q <= prdata_d;
		end
	end

	// ****************************************
	// schedule compare
	// ****************************************
	always_comb begin
		cur_code = 14'(cal_hour) * 14'd100 + 14'(cal_minute);
		mask_bit = mask_q[cal_weekday];
		case (mode_q)
			MODE_NORMAL: day_ok = mask_bit;
			MODE_ADD:    day_ok = mask_bit || tbl.hit;
			MODE_SKIP:   day_ok = mask_bit && !tbl.hit;
			default:     day_ok = 1'b0;
		endcase
		// on later than off: off belongs to the day the on fired
		overnight = (on_q > off_q) && (on_q != `WSC_TIME_OFF);
		// date rolled over: keep yesterday's selection
		rollover  = (cur_code < last_code_q);
		prev_ok_d = rollover ? day_ok_q : prev_ok_q;
		// off at midnight meets the rollover in the same cycle
		off_ok    = overnight ? prev_ok_d : day_ok;
		mode_err  = (mode_q == MODE_BAD);
		mask_err  = (mask_q > `WSC_MASK_MAX);
		time_err  = on_bad || off_bad;
		tbl_err   = (mode_q != MODE_NORMAL) && !tbl.loaded;
		cfg_err   = mode_err || mask_err || time_err || tbl_err;
		run       = en_q && !cfg_err;
		on_fire   = run && on_hit && !on_hit_q && day_ok;
		off_fire  = run && off_hit && !off_hit_q && off_ok;
		out_d     = out_q;
		if (off_fire) begin
			out_d = 1'b0;
		end else if (on_fire) begin
			out_d = 1'b1;
		end
		ev = '0;
		ev[`WSC_ST_ERR] = (en_q && cfg_err) || tbl.bad;
		ev[`WSC_ST_ON]  = on_fire;
		ev[`WSC_ST_OFF] = off_fire;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_q       <= 1'b0;
			on_hit_q    <= 1'b0;
			off_hit_q   <= 1'b0;
			day_ok_q    <= 1'b0;
			prev_ok_q   <= 1'b0;
			last_code_q <= '0;
		end else begin
			out_q       <= out_d;
			on_hit_q    <= on_hit;
			off_hit_q   <= off_hit;
			day_ok_q    <= day_ok;
			prev_ok_q   <= prev_ok_d;
			last_code_q <= cur_code;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign prdata          = prdata_q;
	assign pready          = 1'b1;
	assign pslverr         = psel && penable && !mapped;
	assign schedule_output = out_q;
	assign error_indicator = stat_q[`WSC_ST_ERR];
	assign irq             = |(stat_q & imsk_q);
endmodule // wsc_top

// *** wsc_top_monitor.sv ***
`timescale 1ns/1ps
module wsc_top_monitor (
	input wire logic               pclk,
	input wire logic               presetn,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pwrite,
	input wire logic [7:0]         paddr,
	input wire wsc_pkg::wsc_word_t pwdata,
	input wire logic               pready,
	input wire logic [2:0]         cal_weekday,
	input wire logic [3:0]         cal_month,
	input wire logic [4:0]         cal_day,
	input wire logic [4:0]         cal_hour,
	input wire logic [5:0]         cal_minute,
	input wire logic               schedule_output,
	input wire logic               error_indicator
);
	import wsc_pkg::*;
	// ****************************************
	// shadow of configuration writes
	// ****************************************
	wsc_word_t   ctl_q;
	wsc_word_t   on_q;
	wsc_word_t   off_q;
	logic [7:0]  msk_q;
	logic        ld_q;
	logic        wr;
	logic        sel;
	logic [13:0] now;
	logic [1:0]  md;
	assign wr = psel && penable && pwrite;
	assign now = 14'(cal_hour) * 14'h64 + 14'(cal_minute);
	assign md = ctl_q[3:2];
	assign sel = msk_q[cal_weekday];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_q <= 32'h0;
			on_q <= 32'h2710;
			off_q <= 32'h2710;
			msk_q <= 8'h0;
			ld_q <= 1'b0;
		end else if (wr) begin
			case (paddr)
			8'h00: ctl_q <= pwdata;
			8'h04: msk_q <= pwdata[7:0];
			8'h08: on_q <= pwdata;
			8'h0c: off_q <= pwdata;
			default: ;
			endcase
			if (paddr == 8'h00 && pwdata[1])
				ld_q <= 1'b1;
		end
	end
	// ****************************************
	// properties
	// ****************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_still;
		$stable(cal_hour) && $stable(cal_minute) && $stable(cal_weekday) && $stable(cal_month)
			&& $stable(cal_day) && !psel && !$past(psel);
	endsequence
	property p_hold; s_still |=> $stable(schedule_output); endproperty
	property p_on; $rose(schedule_output) |-> $past(now) == on_q[13:0]; endproperty
	property p_off; $fell(schedule_output) |-> $past(now) == off_q[13:0]; endproperty
	property p_mask; $rose(schedule_output) && md == 2'h0 |-> $past(sel); endproperty
	property p_idle; !ctl_q[0] |=> $stable(schedule_output); endproperty
	property p_bad; ctl_q[0] && (md == 2'h3 || msk_q[7]) |=> error_indicator; endproperty
	property p_noload; ctl_q[0] && (md == 2'h1 || md == 2'h2) && !ld_q |=> error_indicator;
	endproperty
	property p_errclr; $fell(error_indicator) |-> $past(wr); endproperty
	property p_rdy; psel && penable |-> pready; endproperty
	a_hold: assert property (p_hold) else $error("output moved");
	a_on: assert property (p_on) else $error("set off time");
	a_off: assert property (p_off) else $error("clear off time");
	a_mask: assert property (p_mask) else $error("set on idle day");
	a_idle: assert property (p_idle) else $error("moved while off");
	a_bad: assert property (p_bad) else $error("no range error");
	a_noload: assert property (p_noload) else $error("no load error");
	a_errclr: assert property (p_errclr) else $error("error lost");
	a_rdy: assert property (p_rdy) else $error("no ready");
endmodule // wsc_top_monitor

bind wsc_top wsc_top_monitor i_mon (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .cal_weekday(cal_weekday),
	.cal_month(cal_month), .cal_day(cal_day), .cal_hour(cal_hour), .cal_minute(cal_minute),
	.schedule_output(schedule_output), .error_indicator(error_indicator)
);

// *** wsc_cal_model.sv ***
`timescale 1ns/1ps
module wsc_cal_model (
	input  wire logic  pclk,
	output logic [2:0] cal_weekday,
	output logic [3:0] cal_month,
	output logic [4:0] cal_day,
	output logic [4:0] cal_hour,
	output logic [5:0] cal_minute
);
	initial begin
		cal_weekday = 3'h6;
		cal_month = 4'h6;
		cal_day = 5'h6;
		cal_hour = 5'hc;
		cal_minute = 6'h1;
	end
	// weekday 0 sunday to 6 saturday
	task automatic put(input logic [2:0] w, input logic [3:0] m, input logic [4:0] d,
		input logic [4:0] h, input logic [5:0] n);
		@(posedge pclk);
		cal_weekday <= w;
		cal_month <= m;
		cal_day <= d;
		cal_hour <= h;
		cal_minute <= n;
		repeat (3) @(posedge pclk);
	endtask
endmodule // wsc_cal_model

// *** test_weekly_schedule_comparator.sv ***
`timescale 1ns/1ps
module test_weekly_schedule_comparator;
	import wsc_pkg::*;
	logic       pclk, presetn, psel, penable, pwrite, pready, pslverr, sl;
	logic       schedule_output, error_indicator, irq;
	logic [7:0] paddr;
	wsc_word_t  pwdata, prdata, rd;
	logic [2:0] cal_weekday;
	logic [3:0] cal_month;
	logic [4:0] cal_day, cal_hour;
	logic [5:0] cal_minute;
	int         failures, n_compared;
	wsc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cal_weekday(cal_weekday), .cal_month(cal_month),
		.cal_day(cal_day), .cal_hour(cal_hour), .cal_minute(cal_minute),
		.schedule_output(schedule_output), .error_indicator(error_indicator), .irq(irq));
	wsc_cal_model i_cal (.pclk(pclk), .cal_weekday(cal_weekday), .cal_month(cal_month),
		.cal_day(cal_day), .cal_hour(cal_hour), .cal_minute(cal_minute));
	always #12.5 pclk = ~pclk;
	task automatic end_of_test;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input wsc_word_t s, input wsc_word_t e);
		n_compared++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input wsc_word_t d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		if (pready !== 1'b1) begin
			failures++;
			end_of_test();
		end
		rd = prdata;
		sl = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input wsc_word_t d);
		apb(1'b1, a, d);
	endtask
	task automatic out(input wsc_word_t e);
		chk(32'(schedule_output), e);
	endtask
	task automatic err(input wsc_word_t e);
		repeat (2) @(posedge pclk);
		chk(32'(error_indicator), e);
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset;
		out(32'h0);
		chk(32'(error_indicator), 32'h0);
		chk(32'(irq), 32'h0);
		apb(1'b0, 8'h08, 32'h0);
		chk(rd, 32'h2710);
		apb(1'b0, 8'h0c, 32'h0);
		chk(rd, 32'h2710);
		apb(1'b0, 8'h20, 32'h0);
		chk(32'(sl), 32'h1);
		chk(rd, 32'h0);
	endtask
	task automatic t_week;
		wr(8'h04, 32'h3e);
		wr(8'h08, 32'h33e);
		wr(8'h0c, 32'h6a9);
		wr(8'h00, 32'h1);
		i_cal.put(3'h1, 4'h6, 5'h6, 5'h8, 6'h1d);
		out(32'h0);
		i_cal.put(3'h1, 4'h6, 5'h6, 5'h8, 6'h1e);
		out(32'h1);
		i_cal.put(3'h1, 4'h6, 5'h6, 5'h9, 6'h0);
		out(32'h1);
		i_cal.put(3'h1, 4'h6, 5'h6, 5'h11, 6'h5);
		out(32'h0);
		i_cal.put(3'h0, 4'h6, 5'h6, 5'h8, 6'h1e);
		out(32'h0);
	endtask
	task automatic t_night;
		wr(8'h08, 32'h8fc);
		wr(8'h0c, 32'h64);
		i_cal.put(3'h1, 4'h6, 5'h6, 5'h17, 6'h0);
		out(32'h1);
		i_cal.put(3'h2, 4'h6, 5'h7, 5'h0, 6'h0);
		out(32'h1);
		i_cal.put(3'h2, 4'h6, 5'h7, 5'h1, 6'h0);
		out(32'h0);
		wr(8'h0c, 32'h2710);
		i_cal.put(3'h1, 4'h6, 5'h6, 5'h17, 6'h0);
		i_cal.put(3'h2, 4'h6, 5'h7, 5'h1, 6'h0);
		out(32'h1);
		wr(8'h0c, 32'h6a9);
		wr(8'h08, 32'h33e);
		i_cal.put(3'h2, 4'h6, 5'h7, 5'h11, 6'h5);
		out(32'h0);
	endtask
	task automatic t_error;
		wr(8'h00, 32'hd);
		err(32'h1);
		wr(8'h00, 32'h1);
		wr(8'h18, 32'h1);
		@(posedge pclk);
		chk(32'(irq), 32'h1);
		wr(8'h14, 32'h1);
		err(32'h0);
		chk(32'(irq), 32'h0);
		wr(8'h08, 32'h960);
		err(32'h1);
		wr(8'h08, 32'h33e);
		wr(8'h14, 32'h1);
		err(32'h0);
		wr(8'h04, 32'h80);
		err(32'h1);
		wr(8'h04, 32'h3e);
		wr(8'h14, 32'h7);
		err(32'h0);
	endtask
	task automatic t_table;
		wr(8'h40, 32'h4cf);
		wr(8'h44, 32'h65);
		wr(8'h10, 32'h2);
		wr(8'h00, 32'h5);
		err(32'h1);
		wr(8'h00, 32'h7);
		wr(8'h14, 32'h7);
		err(32'h0);
		apb(1'b0, 8'h14, 32'h0);
		chk(rd, 32'h200);
		apb(1'b0, 8'h44, 32'h0);
		chk(rd, 32'h65);
		i_cal.put(3'h0, 4'hc, 5'h1f, 5'h8, 6'h1e);
		out(32'h1);
		i_cal.put(3'h0, 4'hc, 5'h1f, 5'h11, 6'h5);
		out(32'h0);
		wr(8'h00, 32'h9);
		i_cal.put(3'h2, 4'h1, 5'h1, 5'h8, 6'h1e);
		out(32'h0);
		wr(8'h00, 32'h1);
		i_cal.put(3'h0, 4'hc, 5'h1f, 5'h8, 6'h1d);
		i_cal.put(3'h0, 4'hc, 5'h1f, 5'h8, 6'h1e);
		out(32'h0);
		wr(8'h40, 32'h514);
		wr(8'h00, 32'h3);
		err(32'h1);
	endtask
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h0;
		pwdata = 32'h0;
		failures = 0;
		n_compared = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_week();
		t_night();
		t_error();
		t_table();
		end_of_test();
	end
	initial begin
		repeat (20000) @(posedge pclk);
		failures++;
		end_of_test();
	end
endmodule // test_weekly_schedule_comparator
